//--- dv/pds_cmd_model.sv
// Command processor model issuing special-register writes
`timescale 1ns/1ps
`default_nettype none
module pds_cmd_model (
  input wire logic clk_sys,
  output logic spr_valid,
  output logic [3:0] spr_sel,
  output logic [31:0] spr_data
);
  // Idle bus at time zero
  initial
  begin
    spr_valid = 1'b0;
    spr_sel = 4'h0;
    spr_data = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One whole-word write, one-cycle strobe; released bus shows inverted garbage
  // writes issued in order
  task automatic spr_write(input logic [3:0] sel, input logic [31:0] data);
  begin
    @(posedge clk_sys);
    spr_valid <= 1'b1;
    spr_sel <= sel;
    spr_data <= data;
    @(posedge clk_sys);
    spr_valid <= 1'b0;
    spr_sel <= ~sel;
    spr_data <= ~data;
  end
  endtask
endmodule // pds_cmd_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the pixel destination stage
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"
module tb_top;
  // Row of the raster-op table
  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] col;
    logic wr;
    logic rd;
  } pds_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic pix_valid = 1'b0;
  pds_pkg::pds_pix_t pix = '0;
  logic spr_valid;
  logic [3:0] spr_sel;
  logic [31:0] spr_data;
  logic dest_read_needed;
  logic depth_read_needed;
  logic out_valid;
  logic [31:0] out_colour;
  logic out_write;
  logic out_depth_write;
  logic [31:0] out_depth;
  int bad_count = 0;
  int n_compared = 0;
  pds_row_t rows [16];
  pds_pkg::pds_pix_t p;
  logic zp;
  // Fixed source and destination words
  localparam logic [31:0] S_W = 32'h0f0f33cc;
  localparam logic [31:0] D_W = 32'h00ff3c5a;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  pds_cmd_model cmd_u (.clk_sys(clk_sys), .spr_valid(spr_valid), .spr_sel(spr_sel),
    .spr_data(spr_data));
  pds_dest_stage dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .spr_valid(spr_valid),
    .spr_sel(spr_sel), .spr_data(spr_data), .pix_valid(pix_valid), .pix(pix),
    .dest_read_needed(dest_read_needed), .depth_read_needed(depth_read_needed),
    .out_valid(out_valid), .out_colour(out_colour), .out_write(out_write),
    .out_depth_write(out_depth_write), .out_depth(out_depth));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks and verdict
  task automatic check_bit(input logic got, input logic exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic print_verdict();
  begin
    $display("mismatches %0d comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus helpers
  function automatic pds_pkg::pds_pix_t mk(input logic [31:0] s, input logic [31:0] d);
    pds_pkg::pds_pix_t q;
    q = '0;
    q.src = s;
    q.dst = d;
    q.talpha = 8'hff;
    q.fogf = 8'hff;
    return q;
  endfunction
  // Reference raster op
  function automatic logic [31:0] rop_f(input logic [3:0] c, input logic [31:0] s,
    input logic [31:0] d);
    case (c)
      4'h0: return 32'h0;
      4'h1: return ~(s | d);
      4'h2: return ~s & d;
      4'h3: return ~s;
      4'h4: return s & ~d;
      4'h5: return ~d;
      4'h6: return s ^ d;
      4'h7: return ~(s & d);
      4'h8: return s & d;
      4'h9: return ~(s ^ d);
      4'ha: return d;
      4'hb: return ~s | d;
      4'hc: return s;
      4'hd: return s | ~d;
      4'he: return s | d;
      default: return 32'hffffffff;
    endcase
  endfunction
  // Reference depth test
  function automatic logic z_pass(input int c, input logic [31:0] n, input logic [31:0] o);
    case (c)
      0: return 1'b1;
      1: return n < o;
      2: return n == o;
      3: return n <= o;
      4: return n > o;
      5: return n != o;
      6: return n >= o;
      default: return 1'b0;
    endcase
  endfunction
  // Register write, settled one step after the taking edge
  task automatic wr(input logic [3:0] sel, input logic [31:0] data);
  begin
    cmd_u.spr_write(sel, data);
    #1;
  end
  endtask
  // One pixel; outputs are looked at in their single valid cycle
  task automatic send_pix(input pds_pkg::pds_pix_t q);
  begin
    @(posedge clk_sys);
    pix_valid <= 1'b1;
    pix <= q;
    @(posedge clk_sys);
    pix_valid <= 1'b0;
    pix <= ~q;
    #1;
    check_bit(out_valid, 1'b1);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #(25 * 4000);
    bad_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      rows[i].mode = 32'(i);
      rows[i].col = rop_f(4'(i), S_W, D_W);
      rows[i].rd = !(i == 0 || i == 3 || i == 12 || i == 15);
      rows[i].wr = !rows[i].rd || (rows[i].col != D_W);
    end
    repeat (2) @(posedge clk_sys);
    check_bit(out_valid, 1'b0);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check_bit(dest_read_needed, 1'b0);
    // Raster-op table
    for (int i = 0; i < 16; i++)
    begin
      wr(`PDS_SEL_MODE, rows[i].mode);
      check_bit(dest_read_needed, rows[i].rd);
      send_pix(mk(S_W, D_W));
      check_word(out_colour, rows[i].col);
      check_bit(out_write, rows[i].wr);
    end
    // Partial plane mask forces read and merges, replace mode
    wr(`PDS_SEL_MODE, 32'h0000000c);
    wr(`PDS_SEL_PLANE_WRITE_MASK, 32'hffff0000);
    check_bit(dest_read_needed, 1'b1);
    send_pix(mk(S_W, D_W));
    check_word(out_colour, (S_W & 32'hffff0000) | (D_W & 32'h0000ffff));
    wr(`PDS_SEL_PLANE_WRITE_MASK, 32'hffffffff);
    // Blend factor read decisions
    wr(`PDS_SEL_MODE, 32'h0008067c);
    check_bit(dest_read_needed, 1'b0);
    wr(`PDS_SEL_MODE, 32'h0008068c);
    check_bit(dest_read_needed, 1'b1);
    wr(`PDS_SEL_MODE, 32'h0008077c);
    check_bit(dest_read_needed, 1'b1);
    // Read inhibit with override, then unmapped write ignored
    wr(`PDS_SEL_MODE, 32'h0080000a);
    wr(`PDS_SEL_OVR, 32'h5a5a1234);
    check_bit(dest_read_needed, 1'b0);
    send_pix(mk(S_W, D_W));
    check_word(out_colour, 32'h5a5a1234);
    check_bit(out_write, 1'b1);
    wr(4'hd, 32'h0);
    send_pix(mk(S_W, D_W));
    check_word(out_colour, 32'h5a5a1234);
    // A real destination read replaces the override
    wr(`PDS_SEL_MODE, 32'h0000000a);
    send_pix(mk(S_W, 32'h76543210));
    check_bit(out_write, 1'b0);
    wr(`PDS_SEL_MODE, 32'h0080000a);
    send_pix(mk(S_W, D_W));
    check_word(out_colour, 32'h76543210);
    // Depth compare codes, new less than and equal to stored
    for (int c = 0; c < 8; c++)
      for (int e = 0; e < 2; e++)
      begin
        wr(`PDS_SEL_MODE, 32'h0001000c | (32'(c) << 12));
        check_bit(depth_read_needed, c >= 1 && c <= 6);
        p = mk(S_W, D_W);
        p.zn = e ? 32'h9 : 32'h5;
        p.zo = 32'h9;
        zp = z_pass(c, p.zn, p.zo) && !(c >= 1 && c <= 6 && e == 1);
        send_pix(p);
        check_bit(out_depth_write, zp);
        check_word(out_depth, p.zn);
      end
    wr(`PDS_SEL_MODE, 32'h0000000c);
    send_pix(p);
    check_bit(out_depth_write, 1'b0);
    // Transparent pattern of length three, scissored pixel still advances
    wr(`PDS_SEL_PAT, 32'h40000001);
    wr(`PDS_SEL_BG, 32'h11223344);
    wr(`PDS_SEL_PATCTL, 32'h00010002);
    for (int k = 0; k < 5; k++)
    begin
      p = mk(S_W, D_W);
      p.scis = (k == 2);
      send_pix(p);
      check_bit(out_write, k == 0 || k == 3);
    end
    // Opaque: offsets 2, 0 foreground, offset 1 background colour
    wr(`PDS_SEL_PATCTL, 32'h00030002);
    for (int k = 0; k < 3; k++)
    begin
      send_pix(mk(S_W, D_W));
      check_word(out_colour, k < 2 ? S_W : 32'h11223344);
      check_bit(out_write, 1'b1);
    end
    wr(`PDS_SEL_PATCTL, 32'h0);
    // Dither into 565 with phase, saturating red
    wr(`PDS_SEL_FMT, 32'h4);
    wr(`PDS_SEL_DPH, 32'h13);
    wr(`PDS_SEL_MODE, 32'h0010000c);
    p = mk(32'h00fe073c, D_W);
    p.x = 2'h1;
    p.y = 2'h2;
    send_pix(p);
    check_word(out_colour, 32'hf848f848);
    wr(`PDS_SEL_MODE, 32'h0000000c);
    send_pix(p);
    check_word(out_colour, 32'hf827f827);
    wr(`PDS_SEL_FMT, 32'hc);
    // Fog factor extremes
    wr(`PDS_SEL_FOG, 32'h00123456);
    wr(`PDS_SEL_MODE, 32'h0020000c);
    for (int k = 0; k < 2; k++)
    begin
      p = mk(32'h80abcdef, D_W);
      p.fogf = k ? 8'hff : 8'h00;
      send_pix(p);
      check_word(out_colour, k ? 32'h80abcdef : 32'h80123456);
    end
    // Alpha threshold at and above the level
    wr(`PDS_SEL_AREF, 32'h80);
    wr(`PDS_SEL_MODE, 32'h0200000c);
    for (int k = 0; k < 2; k++)
    begin
      p = mk(S_W, D_W);
      p.talpha = 8'h80 + 8'(k);
      send_pix(p);
      check_bit(out_write, k == 1);
    end
    // Source alpha over destination, then colour conversion
    wr(`PDS_SEL_MODE, 32'h0008032c);
    send_pix(mk(32'h80ff0000, 32'h000000ff));
    check_word(out_colour, 32'h407f007e);
    wr(`PDS_SEL_MODE, 32'h0004000c);
    send_pix(mk(32'h00808080, D_W));
    check_word(out_colour, 32'h00595959);
    // Zero plane mask with a read blocks the write
    wr(`PDS_SEL_PLANE_WRITE_MASK, 32'h0);
    wr(`PDS_SEL_MODE, 32'h0000000a);
    send_pix(mk(S_W, D_W));
    check_bit(out_write, 1'b0);
    // Foreground layout and RGB-only write
    wr(`PDS_SEL_FG, 32'h11223344);
    wr(`PDS_SEL_FGRGB, 32'haabbccdd);
    check_word(dut_u.st_reg.fg, 32'h11bbccdd);
    // Mid-run reset restores mode and mask
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check_bit(dest_read_needed, 1'b0);
    send_pix(mk(S_W, D_W));
    check_word(out_colour, 32'h0);
    @(posedge clk_sys);
    #1;
    check_bit(out_valid, 1'b0);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire

//--- inc/pds_params.svh
// Constants for the pixel destination stage
`ifndef PDS_PARAMS_SVH
`define PDS_PARAMS_SVH
// Register select codes on the special-register write port
`define PDS_SEL_MODE 4'h0
`define PDS_SEL_FMT 4'h1
`define PDS_SEL_PLANE_WRITE_MASK 4'h2
`define PDS_SEL_PAT 4'h3
`define PDS_SEL_PATCTL 4'h4
`define PDS_SEL_DPH 4'h5
`define PDS_SEL_FG 4'h6
`define PDS_SEL_FGRGB 4'h7
`define PDS_SEL_BG 4'h8
`define PDS_SEL_FOG 4'h9
`define PDS_SEL_OVR 4'ha
`define PDS_SEL_AREF 4'hb
// Destination mode fields
`define PDS_ROP 3:0
`define PDS_SBF 7:4
`define PDS_DBF 11:8
`define PDS_ZCMP 14:12
`define PDS_ZWR 16
`define PDS_YUV 18
`define PDS_BLEND 19
`define PDS_DITHER 20
`define PDS_FOGON 21
`define PDS_NOPAD 22
`define PDS_RDINH 23
`define PDS_AREJ 25
// Pattern control fields
`define PDS_PLEN 4:0
`define PDS_PON 16
`define PDS_POPQ 17
// Dither phase fields
`define PDS_DX 1:0
`define PDS_DY 5:4
// Reset values
`define PDS_RST_FMT 4'hc
`define PDS_RST_PLANE_WRITE_MASK 32'hffffffff
// Colour space contrast default
`define PDS_YUV_CONTRAST 41
`endif

//--- inc/pds_pkg.sv
// Types for the pixel destination stage
package pds_pkg;
  // One pixel presented by the upstream engine
  typedef struct packed {
    logic [31:0] src;
    logic [7:0] talpha;
    logic [7:0] fogf;
    logic [1:0] x;
    logic [1:0] y;
    logic [31:0] zn;
    logic [31:0] zo;
    logic [31:0] dst;
    logic scis;
  } pds_pix_t;
  // All state of the stage
  typedef struct packed {
    logic [31:0] mode;
    logic [3:0] fmt;
    logic [31:0] plane_write_mask;
    logic [31:0] pat;
    logic [31:0] patctl;
    logic [5:0] dph;
    logic [31:0] fg;
    logic [31:0] bg;
    logic [31:0] fog;
    logic [31:0] ovr;
    logic [7:0] aref;
    logic [4:0] poff;
    logic ov;
    logic [31:0] od;
    logic ow;
    logic ozw;
    logic [31:0] oz;
  } pds_state_t;
endpackage

//--- rtl/pds_dest_stage.sv
// Pixel destination stage: raster op, blend, depth, pattern, dither, fog
//
// Contract
// - raster op selects sixteen logic functions
// - source blend factor selection
// - destination blend factor selection
// - depth compare picks replace condition
// - depth write gated, equal depth skipped when the compare code reads depth (1 to 6)
// - colour space conversion replaces blending
// - blend, dither, fog enabled by bits
// - destination expand zero-fill or rounded
// - read inhibit uses override colour
// - low alpha pixels are not written
// - destination pixel format encoding
// - plane mask gates writes per bit
// - pattern bit is negated offset
// - pattern offset advances and wraps
// - background pixels opaque or untouched
// - pattern control length, enable, opaque
// - dither phase added modulo four
// - fixed four by four dither matrix
// - dither add, saturate, shift down
// - foreground byte layout, RGB-only write
// - fog blends toward fog colour
// - destination read overwrites override
// - destination read decision equation
// - equal result with read skips write
`timescale 1ns/1ps
`default_nettype none
`include "pds_params.svh"
module pds_dest_stage (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic spr_valid,
  input wire logic [3:0] spr_sel,
  input wire logic [31:0] spr_data,
  input wire logic pix_valid,
  input wire pds_pkg::pds_pix_t pix,
  output logic dest_read_needed,
  output logic depth_read_needed,
  output logic out_valid,
  output logic [31:0] out_colour,
  output logic out_write,
  output logic out_depth_write,
  output logic [31:0] out_depth
);
  ////////////////////////////////////////////////////////////////////
  // Dither matrix, index {y, x}
  // fixed matrix
  localparam logic [3:0] DM [16] = '{
    4'h0, 4'hc, 4'h3, 4'hf, 4'h7, 4'hb, 4'h4, 4'h8,
    4'hd, 4'h1, 4'he, 4'h2, 4'ha, 4'h6, 4'h9, 4'h5};
  pds_pkg::pds_state_t st_reg; // Registered state
  pds_pkg::pds_state_t st_next; // Next state
  ////////////////////////////////////////////////////////////////////
  // Raster op on packed words
  function automatic logic [31:0] rop(input logic [3:0] m,
    input logic [31:0] s, input logic [31:0] d);
    case (m)
      4'h0: rop = 32'h0;
      4'h1: rop = ~(s | d);
      4'h2: rop = ~s & d;
      4'h3: rop = ~s;
      4'h4: rop = s & ~d;
      4'h5: rop = ~d;
      4'h6: rop = s ^ d;
      4'h7: rop = ~(s & d);
      4'h8: rop = s & d;
      4'h9: rop = ~(s ^ d);
      4'ha: rop = d;
      4'hb: rop = ~s | d;
      4'hc: rop = s;
      4'hd: rop = s | ~d;
      4'he: rop = s | d;
      default: rop = 32'hffffffff;
    endcase
  endfunction
  // Blend factor, 256 means one
  function automatic logic [8:0] fac(input logic [3:0] f,
    input logic dsd, input logic [7:0] s, input logic [7:0] d,
    input logic [7:0] as, input logic [7:0] ad);
    logic [7:0] sat;
    sat = (as < (8'hff - ad)) ? as : (8'hff - ad);
    case (f)
      4'h0: fac = {1'b0, dsd ? s : d};
      4'h1: fac = {1'b0, ~(dsd ? s : d)};
      4'h2: fac = {1'b0, as};
      4'h3: fac = {1'b0, ~as};
      4'h4: fac = {1'b0, ad};
      4'h5: fac = {1'b0, ~ad};
      4'h7: fac = 9'h100;
      4'h8: fac = {1'b0, sat};
      4'h9: fac = {1'b0, ~sat};
      4'ha: fac = {1'b0, dsd ? d : s};
      4'hb: fac = {1'b0, ~(dsd ? d : s)};
      default: fac = 9'h0;
    endcase
  endfunction
  // One blended channel
  function automatic logic [7:0] bl(input logic [3:0] fs,
    input logic [3:0] fd, input logic [7:0] s, input logic [7:0] d,
    input logic [7:0] as, input logic [7:0] ad);
    logic [17:0] t;
    logic [9:0] u;
    t = 18'h0;
    u = 10'(s) + 10'(d);
    // Signed add: destination biased by half
    if (fs == 4'hf || fd == 4'hf)
    begin
      if (u < 10'h080)
        bl = 8'h0;
      else if (u > 10'h17f)
        bl = 8'hff;
      else
        bl = 8'(u - 10'h080);
    end
    else
    begin
      t = 18'(s) * 18'(fac(fs, 1'b0, s, d, as, ad))
        + 18'(d) * 18'(fac(fd, 1'b1, s, d, as, ad));
      bl = (t[17:8] > 10'h0ff) ? 8'hff : t[15:8];
    end
  endfunction
  // Clamp to a byte
  function automatic logic [7:0] clp(input int v);
    clp = (v < 0) ? 8'h0 : (v > 255) ? 8'hff : 8'(v);
  endfunction
  // YUV to RGB, alpha kept
  function automatic logic [31:0] yuv(input logic [31:0] c,
    input logic [7:0] blk);
    int sy;
    int cr;
    int cb;
    sy = (`PDS_YUV_CONTRAST + 256) * (int'(c[15:8]) - int'(blk)) + 128;
    cr = int'(c[23:16]) - 128;
    cb = int'(c[7:0]) - 128;
    yuv = {c[31:24], clp((sy + 407 * cr) / 255),
      clp((sy - 207 * cr - 100 * cb) / 255), clp((sy + 515 * cb) / 255)};
  endfunction
  // Fog one channel
  function automatic logic [7:0] fg1(input logic [7:0] f,
    input logic [7:0] s, input logic [7:0] c);
    fg1 = 8'((16'(f) * 16'(s) + 16'(8'hff - f) * 16'(c)) / 16'd255);
  endfunction
  // Reduce a channel to n bits
  function automatic logic [7:0] red(input logic [7:0] c,
    input logic [3:0] dv, input int n, input logic on);
    logic [8:0] t;
    logic [7:0] ad;
    case (n)
      6: ad = 8'(dv >> 2);
      5, 4: ad = 8'(dv >> 1);
      3: ad = 8'(dv) << 1;
      2: ad = 8'(dv) << 2;
      default: ad = 8'h0;
    endcase
    if (!on)
      ad = 8'h0;
    t = 9'(c) + 9'(ad);
    if (t > 9'h0ff)
      t = 9'h0ff;
    red = t[7:0] >> (8 - n);
  endfunction
  // Pack ARGB to destination word, replicated
  function automatic logic [31:0] pack(input logic [3:0] f,
    input logic [31:0] c, input logic [3:0] dv, input logic on);
    logic [7:0] a;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    {a, r, g, b} = c;
    case (f)
      4'h1: pack = {4{3'(red(r, dv, 3, on)), 3'(red(g, dv, 3, on)),
        2'(red(b, dv, 2, on))}};
      4'h2: pack = {4{r}};
      4'h3: pack = {4{a}};
      4'h4: pack = {2{5'(red(r, dv, 5, on)), 6'(red(g, dv, 6, on)),
        5'(red(b, dv, 5, on))}};
      4'h5: pack = {2{4'(red(a, dv, 4, on)), 4'(red(r, dv, 4, on)),
        4'(red(g, dv, 4, on)), 4'(red(b, dv, 4, on))}};
      4'h6: pack = {2{a[7], 5'(red(r, dv, 5, on)),
        5'(red(g, dv, 5, on)), 5'(red(b, dv, 5, on))}};
      4'hc: pack = c;
      default: pack = 32'h0;
    endcase
  endfunction
  // Expand n bits to 8
  function automatic logic [7:0] ex(input logic [7:0] v, input int n,
    input logic np);
    logic [15:0] t;
    t = 16'(v);
    case (n)
      1: t = (16'(v) * 16'd510 + 16'd1) / 16'd2;
      2: t = (16'(v) * 16'd510 + 16'd3) / 16'd6;
      3: t = (16'(v) * 16'd510 + 16'd7) / 16'd14;
      4: t = (16'(v) * 16'd510 + 16'd15) / 16'd30;
      5: t = (16'(v) * 16'd510 + 16'd31) / 16'd62;
      6: t = (16'(v) * 16'd510 + 16'd63) / 16'd126;
      default: t = 16'(v);
    endcase
    ex = np ? (v << (8 - n)) : t[7:0];
  endfunction
  // Destination word to ARGB
  function automatic logic [31:0] unpk(input logic [3:0] f,
    input logic [31:0] w, input logic np);
    case (f)
      4'h1: unpk = {8'hff, ex(8'(w[7:5]), 3, np), ex(8'(w[4:2]), 3, np),
        ex(8'(w[1:0]), 2, np)};
      4'h2: unpk = {8'hff, {3{w[7:0]}}};
      4'h3: unpk = {w[7:0], 24'h0};
      4'h4: unpk = {8'hff, ex(8'(w[15:11]), 5, np),
        ex(8'(w[10:5]), 6, np), ex(8'(w[4:0]), 5, np)};
      4'h5: unpk = {ex(8'(w[15:12]), 4, np), ex(8'(w[11:8]), 4, np),
        ex(8'(w[7:4]), 4, np), ex(8'(w[3:0]), 4, np)};
      4'h6: unpk = {ex(8'(w[15]), 1, np), ex(8'(w[14:10]), 5, np),
        ex(8'(w[9:5]), 5, np), ex(8'(w[4:0]), 5, np)};
      default: unpk = w;
    endcase
  endfunction
  // Depth test
  function automatic logic zpass(input logic [2:0] m,
    input logic [31:0] n, input logic [31:0] o);
    case (m)
      3'h0: zpass = 1'b1;
      3'h1: zpass = n < o;
      3'h2: zpass = n == o;
      3'h3: zpass = n <= o;
      3'h4: zpass = n > o;
      3'h5: zpass = n != o;
      3'h6: zpass = n >= o;
      default: zpass = 1'b0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////
  // Read decisions from the settings
  logic [3:0] rop_m; // Raster op code
  logic [3:0] sbf; // Source factor
  logic rop_d; // Raster op uses destination
  logic pm_part; // Partial plane mask
  logic bl_d; // Blend needs destination
  always_comb
  begin
    rop_m = st_reg.mode[`PDS_ROP];
    sbf = st_reg.mode[`PDS_SBF];
    rop_d = !(rop_m == 4'h0 || rop_m == 4'h3 || rop_m == 4'hc
      || rop_m == 4'hf);
    pm_part = st_reg.plane_write_mask != 32'hffffffff && st_reg.plane_write_mask != 32'h0;
    bl_d = st_reg.mode[`PDS_BLEND] && ((sbf <= 4'h1)
      || (sbf == 4'h4) || (sbf == 4'h5) || (sbf == 4'h8)
      || (sbf == 4'h9) || (st_reg.mode[`PDS_DBF] != 4'h6));
    dest_read_needed = !st_reg.mode[`PDS_RDINH]
      && (pm_part || rop_d || bl_d);
    depth_read_needed = st_reg.mode[`PDS_ZCMP] != 3'h0
      && st_reg.mode[`PDS_ZCMP] != 3'h7;
  end
  ////////////////////////////////////////////////////////////////////
  // Pixel datapath
  logic [4:0] pidx; // Current pattern bit
  logic bgpix; // Background pixel
  logic pskip; // Transparent background
  logic arej; // Alpha reject
  logic [31:0] dsel; // Destination raw word
  logic [31:0] d8; // Destination ARGB
  logic [31:0] s8; // Source ARGB
  logic [31:0] c1; // After blend stage
  logic [31:0] c2; // After fog
  logic [3:0] dv; // Dither value
  logic [31:0] pk; // Packed result
  logic [31:0] mr; // Masked result
  logic wr; // Colour write
  logic zw; // Depth write
  always_comb
  begin
    pidx = 5'h0 - st_reg.poff;
    bgpix = st_reg.patctl[`PDS_PON] && !st_reg.pat[pidx];
    pskip = bgpix && !st_reg.patctl[`PDS_POPQ];
    s8 = bgpix ? st_reg.bg : pix.src;
    arej = st_reg.mode[`PDS_AREJ] && (pix.talpha <= st_reg.aref);
    dsel = dest_read_needed ? pix.dst : st_reg.ovr;
    d8 = unpk(st_reg.fmt, dsel, st_reg.mode[`PDS_NOPAD]);
    if (st_reg.mode[`PDS_YUV])
      c1 = yuv(s8, st_reg.fog[15:8]);
    else if (st_reg.mode[`PDS_BLEND])
      for (int i = 0; i < 4; i++)
        c1[i*8 +: 8] = bl(sbf, st_reg.mode[`PDS_DBF], s8[i*8 +: 8],
          d8[i*8 +: 8], s8[31:24], d8[31:24]);
    else
      c1 = s8;
    c2 = c1;
    if (st_reg.mode[`PDS_FOGON] && !st_reg.mode[`PDS_YUV])
      for (int i = 0; i < 3; i++)
        c2[i*8 +: 8] = fg1(pix.fogf, c1[i*8 +: 8],
          st_reg.fog[i*8 +: 8]);
    dv = DM[{2'(pix.y + st_reg.dph[`PDS_DY]),
      2'(pix.x + st_reg.dph[`PDS_DX])}];
    pk = pack(st_reg.fmt, c2, dv, st_reg.mode[`PDS_DITHER]);
    mr = (rop(rop_m, pk, dsel) & st_reg.plane_write_mask) | (dsel & ~st_reg.plane_write_mask);
    wr = pix_valid && !pix.scis && !pskip && !arej
      && !(dest_read_needed && mr == dsel);
    zw = pix_valid && !pix.scis && !pskip && !arej
      && st_reg.mode[`PDS_ZWR]
      && zpass(st_reg.mode[`PDS_ZCMP], pix.zn, pix.zo)
      && (!depth_read_needed || pix.zn != pix.zo);
  end
  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.ov = pix_valid;
    st_next.od = mr;
    st_next.ow = wr;
    st_next.ozw = zw;
    st_next.oz = pix.zn;
    if (pix_valid && st_reg.patctl[`PDS_PON])
      st_next.poff = (st_reg.poff == st_reg.patctl[`PDS_PLEN])
        ? 5'h0 : st_reg.poff + 5'h1;
    if (pix_valid && dest_read_needed)
      st_next.ovr = pix.dst;
    if (spr_valid)
    begin
      case (spr_sel)
        `PDS_SEL_MODE: st_next.mode = spr_data;
        `PDS_SEL_FMT: st_next.fmt = spr_data[3:0];
        `PDS_SEL_PLANE_WRITE_MASK: st_next.plane_write_mask = spr_data;
        `PDS_SEL_PAT: st_next.pat = spr_data;
        `PDS_SEL_PATCTL: st_next.patctl = spr_data;
        `PDS_SEL_DPH: st_next.dph = spr_data[5:0];
        `PDS_SEL_FG: st_next.fg = spr_data;
        `PDS_SEL_FGRGB: st_next.fg[23:0] = spr_data[23:0];
        `PDS_SEL_BG: st_next.bg = spr_data;
        `PDS_SEL_FOG: st_next.fog = spr_data;
        `PDS_SEL_OVR: st_next.ovr = spr_data;
        `PDS_SEL_AREF: st_next.aref = spr_data[7:0];
        default: st_next.aref = st_next.aref;
      endcase
    end
  end
  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.fmt <= `PDS_RST_FMT;
      st_reg.plane_write_mask <= `PDS_RST_PLANE_WRITE_MASK;
    end
    else
      st_reg <= st_next;
  end
  // Outputs from flops
  assign out_valid = st_reg.ov;
  assign out_colour = st_reg.od;
  assign out_write = st_reg.ow;
  assign out_depth_write = st_reg.ozw;
  assign out_depth = st_reg.oz;
  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_inh;
    @(posedge clk_sys) disable iff (!rst_n)
    st_reg.mode[`PDS_RDINH] |-> !dest_read_needed;
  endproperty
  a_inh: assert property (p_inh) else $error("read while inhibited");
  property p_xor;
    @(posedge clk_sys) disable iff (!rst_n)
    !st_reg.mode[`PDS_RDINH] && rop_m == 4'h6 |-> dest_read_needed;
  endproperty
  a_xor: assert property (p_xor) else $error("xor without read");
  property p_zoff;
    @(posedge clk_sys) disable iff (!rst_n)
    pix_valid && !st_reg.mode[`PDS_ZWR] |=> !out_depth_write;
  endproperty
  a_zoff: assert property (p_zoff) else $error("depth write when off");
  property p_znev;
    @(posedge clk_sys) disable iff (!rst_n)
    pix_valid && st_reg.mode[`PDS_ZCMP] == 3'h7 |=> !out_depth_write;
  endproperty
  a_znev: assert property (p_znev) else $error("never compare wrote");
  property p_arej;
    @(posedge clk_sys) disable iff (!rst_n)
    pix_valid && st_reg.mode[`PDS_AREJ] && pix.talpha <= st_reg.aref
      |=> out_valid && !out_write;
  endproperty
  a_arej: assert property (p_arej) else $error("rejected pixel written");
  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
    pix_valid && st_reg.patctl[`PDS_PON]
      && st_reg.poff == st_reg.patctl[`PDS_PLEN] |=> st_reg.poff == 5'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pattern did not wrap");
  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    !pix_valid ##1 !pix_valid |-> $stable(st_reg.poff);
  endproperty
  a_hold: assert property (p_hold) else $error("pattern moved idle");
  property p_ovr;
    @(posedge clk_sys) disable iff (!rst_n)
    pix_valid && dest_read_needed && !spr_valid
      |=> st_reg.ovr == $past(pix.dst);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not replaced");
  property p_pm0;
    @(posedge clk_sys) disable iff (!rst_n)
    pix_valid && dest_read_needed && st_reg.plane_write_mask == 32'h0 |=> !out_write;
  endproperty
  a_pm0: assert property (p_pm0) else $error("masked pixel written");
  property p_tr;
    @(posedge clk_sys) disable iff (!rst_n)
    pix_valid && bgpix && !st_reg.patctl[`PDS_POPQ] |=> !out_write;
  endproperty
  a_tr: assert property (p_tr) else $error("transparent bg written");
endmodule // pds_dest_stage
`default_nettype wire
